// *** pkg/scmc_pkg.sv ***
package scmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SCMC_CLOCK_MODE_OFF = 8'h00;
  localparam logic [7:0] SCMC_SLEEP_CTRL_OFF = 8'h04;
  localparam logic [7:0] SCMC_STATUS_OFF = 8'h08;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int SCMC_CM_OSC_STOP_BIT = 0;
  localparam int SCMC_CM_SRC_SUB_BIT = 1;
  localparam int SCMC_CM_DIV_LSB = 2;
  localparam int SCMC_CM_DIV_MSB = 3;
  localparam logic [7:0] SCMC_CM_RESET = 8'h00;
  localparam logic [7:0] SCMC_CM_WR_MASK = 8'h0F;
  localparam int SCMC_SLEEP_EN_BIT = 0;
  localparam int SCMC_ST_MODE_LSB = 0;
  localparam int SCMC_ST_MODE_MSB = 1;
  localparam int SCMC_ST_MAIN_ON_BIT = 2;
  localparam int SCMC_ST_SRC_SUB_BIT = 3;

  // ----------------------------------------------------------------
  // CPU divider select codes and terminal counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SCMC_DIV_SEL_2 = 2'h0;
  localparam logic [1:0] SCMC_DIV_SEL_8 = 2'h1;
  localparam logic [1:0] SCMC_DIV_SEL_16 = 2'h2;
  localparam logic [1:0] SCMC_DIV_SEL_64 = 2'h3;
  localparam int SCMC_DIV_W = 6;
  localparam logic [5:0] SCMC_DIV2_LAST = 6'h01;
  localparam logic [5:0] SCMC_DIV8_LAST = 6'h07;
  localparam logic [5:0] SCMC_DIV16_LAST = 6'h0F;
  localparam logic [5:0] SCMC_DIV64_LAST = 6'h3F;

  // ----------------------------------------------------------------
  // Peripheral prescaler: taps 0 (undivided) up to 10 (/1024)
  // ----------------------------------------------------------------
  localparam int SCMC_PRE_W = 10;
  localparam int SCMC_TAPS = 11;

  // ----------------------------------------------------------------
  // Reported operating mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SCMC_MODE_MAIN_ACT = 2'h0;
  localparam logic [1:0] SCMC_MODE_SUB_ACT = 2'h1;
  localparam logic [1:0] SCMC_MODE_SLEEP = 2'h2;
  localparam logic [1:0] SCMC_MODE_STOP = 2'h3;

  typedef enum logic [1:0] {SCMC_RUN, SCMC_SLEEP, SCMC_STOP} scmc_state_t;

  function automatic logic [5:0] scmc_div_last(input logic [1:0] sel);
    case (sel)
      SCMC_DIV_SEL_2: scmc_div_last = SCMC_DIV2_LAST;
      SCMC_DIV_SEL_8: scmc_div_last = SCMC_DIV8_LAST;
      SCMC_DIV_SEL_16: scmc_div_last = SCMC_DIV16_LAST;
      default: scmc_div_last = SCMC_DIV64_LAST;
    endcase
  endfunction

endpackage

// *** sim/scmc_osc_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Oscillator pair feeding the clock controller
// ----------------------------------------------------------------
module scmc_osc_model
(
  input wire logic hclk,
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  output logic main_osc_tick,
  output logic sub_osc_tick
);
  logic [1:0] sub_cnt = 2'h0;

  initial main_osc_tick = 1'b0;
  initial sub_osc_tick = 1'b0;

  // A stopped main oscillator gives no edges at all
  always @(posedge hclk)
  begin
    main_osc_tick <= main_osc_en & ~main_osc_tick;
  end

  // Sub oscillator is slower and keeps running in every mode
  always @(posedge hclk)
  begin
    sub_cnt <= (sub_cnt == 2'h2) ? 2'h0 : sub_cnt + 2'h1;
    sub_osc_tick <= sub_osc_en & (sub_cnt == 2'h2);
  end
endmodule // scmc_osc_model

// *** sim/system_clock_mode_control_tb.sv ***
`timescale 1ns/1ps
module system_clock_mode_control_tb;
  import scmc_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic stop_exec = 1'b0;
  logic irq_pending = 1'b0;
  logic on_sub = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] wake = 5'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, cpu_clk_en, main_osc_en, sub_osc_en, m_tick, s_tick;
  wire logic [10:0] periph_tick;
  wire logic [1:0] op_mode;
  int mismatches = 0;
  int n_compared = 0;
  int tap = 11;
  int g, i, nc, np;
  int ndiv[4] = '{2, 8, 16, 64};
  wire logic ev = (tap == 11) ? cpu_clk_en : periph_tick[tap];
  wire logic src = on_sub ? s_tick : m_tick;

  scmc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .main_osc_tick(m_tick), .sub_osc_tick(s_tick),
    .stop_exec(stop_exec), .irq_pending(irq_pending), .key_scan_irq(wake[0]),
    .watch_timer_irq(wake[1]), .timer_event_input(wake[2]),
    .serial_port_unit_event(wake[3]), .ext_irq(wake[4]), .cpu_clk_en(cpu_clk_en),
    .periph_tick(periph_tick), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .op_mode(op_mode));

  scmc_osc_model osc (.hclk(hclk), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .main_osc_tick(m_tick), .sub_osc_tick(s_tick));

  initial forever #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tmo;
    mismatches++;
    $display("MISMATCH wait limit reached");
    wrap_up;
  endtask

  // Never assume zero wait states; poll ready under a bound
  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++k > 50) tmo;
      @(posedge hclk);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  // Source ticks between two consecutive pulses of the watched output
  task gap(output int n);
    int k;
    k = 0;
    n = 0;
    do begin @(posedge hclk); if (++k > 5000) tmo; end while (ev !== 1'b1);
    do begin @(posedge hclk); n += (src === 1'b1); if (++k > 9000) tmo; end
    while (ev !== 1'b1);
  endtask

  task win(input int c, output int ncpu, output int nper);
    ncpu = 0;
    nper = 0;
    repeat (c)
    begin
      @(posedge hclk);
      ncpu += (cpu_clk_en === 1'b1);
      nper += (periph_tick[0] === 1'b1);
    end
  endtask

  task rst;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task pulse_stop;
    stop_exec <= 1'b1;
    @(posedge hclk);
    stop_exec <= 1'b0;
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, SCMC_CLOCK_MODE_OFF, 0); chk("clock_mode", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(0, SCMC_STATUS_OFF, 0); chk("status", 32'h4, rd);
    bus(0, 8'h0C, 0); chk("unmapped", 32'h0, rd);
    gap(g); chk("cpu div after reset", 2, g);
    for (i = 0; i < 4; i++)
    begin
      bus(1, SCMC_CLOCK_MODE_OFF, i << 2);
      gap(g);
      gap(g); chk("cpu div", ndiv[i], g);
    end
    bus(1, SCMC_CLOCK_MODE_OFF, 0);
    for (tap = 0; tap < 11; tap++)
    begin
      gap(g); chk("periph tap", 1 << tap, g);
    end
    // Switch to sub, then stop main, without pausing the CPU clock
    bus(1, SCMC_CLOCK_MODE_OFF, 2);
    on_sub = 1'b1;
    gap(g);
    gap(g); chk("sub div", 2, g);
    bus(0, SCMC_STATUS_OFF, 0); chk("status sub", 32'hD, rd);
    bus(1, SCMC_CLOCK_MODE_OFF, 3);
    bus(0, SCMC_STATUS_OFF, 0); chk("status main off", 32'h9, rd);
    gap(g); chk("sub running", 2, g);
    bus(1, SCMC_CLOCK_MODE_OFF, 2);
    bus(0, SCMC_STATUS_OFF, 0); chk("main restarted", 32'hD, rd);
    // Shortened warm-up: the real delay would exceed the run budget
    repeat (100) @(posedge hclk);
    bus(1, SCMC_CLOCK_MODE_OFF, 0);
    on_sub = 1'b0;
    gap(g);
    gap(g); chk("back on main", 2, g);
    bus(1, SCMC_CLOCK_MODE_OFF, 3);
    repeat (10) @(posedge hclk);
    chk("in sub before reset", 32'h1, {30'h0, op_mode});
    rst;
    bus(0, SCMC_CLOCK_MODE_OFF, 0); chk("reset in sub", 32'h0, rd);
    chk("mode after reset", 32'h0, {30'h0, op_mode});
    // Sleep: CPU clock off, peripheral ticks unaffected
    bus(1, SCMC_SLEEP_CTRL_OFF, 1);
    @(posedge hclk);
    chk("sleep mode", 32'h2, {30'h0, op_mode});
    bus(0, SCMC_SLEEP_CTRL_OFF, 0); chk("sleep flag", 32'h1, rd);
    win(200, nc, np);
    chk("cpu in sleep", 0, nc);
    chk("periph in sleep", 100, np);
    irq_pending <= 1'b1;
    repeat (2) @(posedge hclk);
    irq_pending <= 1'b0;
    chk("sleep release", 32'h0, {30'h0, op_mode});
    // A pending interrupt wins over a sleep request in the same cycle
    @(posedge hclk);
    irq_pending <= 1'b1;
    bus(1, SCMC_SLEEP_CTRL_OFF, 1);
    @(posedge hclk);
    irq_pending <= 1'b0;
    chk("sleep refused", 32'h0, {30'h0, op_mode});
    bus(1, SCMC_SLEEP_CTRL_OFF, 1);
    @(posedge hclk);
    chk("sleep again", 32'h2, {30'h0, op_mode});
    rst;
    chk("sleep reset", 32'h0, {30'h0, op_mode});
    // Every wake source releases stop; state written during stop is refused
    for (i = 0; i < 5; i++)
    begin
      pulse_stop;
      chk("stop mode", 32'h3, {30'h0, op_mode});
      chk("main osc in stop", 32'h0, {31'h0, main_osc_en});
      chk("sub osc in stop", 32'h1, {31'h0, sub_osc_en});
      bus(1, SCMC_CLOCK_MODE_OFF, 32'hC);
      win(100, nc, np);
      chk("periph in stop", 0, np);
      chk("cpu in stop", 0, nc);
      wake <= 5'h1 << i;
      @(posedge hclk);
      wake <= 5'h0;
      @(posedge hclk);
      chk("stop release", 32'h0, {30'h0, op_mode});
      bus(0, SCMC_CLOCK_MODE_OFF, 0); chk("held register", 32'h0, rd);
    end
    pulse_stop;
    rst;
    chk("reset from stop", 32'h0, {30'h0, op_mode});
    wrap_up;
  end
endmodule // system_clock_mode_control_tb

// *** src/scmc_clk_select.sv ***
`timescale 1ns/1ps
module scmc_clk_select
  import scmc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic main_tick,
  input wire logic sub_tick,
  input wire logic run_en,
  input wire logic want_sub,
  input wire logic [1:0] div_sel,
  output logic src_tick,
  output logic cpu_tick,
  output logic src_is_sub
);
  import scmc_pkg::*;

  logic [1:0] div_cur;
  logic [1:0] next_div_cur;
  logic [SCMC_DIV_W-1:0] cnt;
  logic [SCMC_DIV_W-1:0] next_cnt;
  logic next_src_is_sub;

  // Frozen in stop so the divider phase survives
  assign src_tick = run_en & (src_is_sub ? sub_tick : main_tick);
  assign cpu_tick = src_tick & (cnt == scmc_div_last(div_cur)); // [R1]

  always_comb
  begin
    next_cnt = cnt;
    next_div_cur = div_cur;
    next_src_is_sub = src_is_sub;
    if (cpu_tick)
    begin
      // Source and divider change only at a whole CPU period boundary [R19]
      next_cnt = '0;
      next_div_cur = div_sel; // [R1]
      next_src_is_sub = want_sub; // [R4]
    end
    else if (src_tick)
    begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= '0;
      div_cur <= SCMC_DIV_SEL_2; // [R6]
      src_is_sub <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      div_cur <= next_div_cur;
      src_is_sub <= next_src_is_sub;
    end
  end

  property p_cnt_in_range;
    @(posedge hclk) disable iff (!hresetn)
    cnt <= scmc_div_last(div_cur);
  endproperty
  a_cnt_in_range: assert property (p_cnt_in_range) else $error("divider count overrun"); // [R1]

  property p_switch_on_boundary;
    @(posedge hclk) disable iff (!hresetn)
    ($changed(src_is_sub) || $changed(div_cur)) |-> $past(cpu_tick);
  endproperty
  a_switch_on_boundary: assert property (p_switch_on_boundary) else $error("mid-period switch"); // [R19]

  property p_cpu_on_edge;
    @(posedge hclk) disable iff (!hresetn)
    cpu_tick |-> src_tick ##1 (cnt == '0);
  endproperty
  a_cpu_on_edge: assert property (p_cpu_on_edge) else $error("cpu tick off source edge"); // [R19]

endmodule // scmc_clk_select

// *** src/scmc_prescaler.sv ***
`timescale 1ns/1ps
module scmc_prescaler
  import scmc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic src_tick,
  output logic [scmc_pkg::SCMC_TAPS-1:0] periph_tick
);
  import scmc_pkg::*;

  logic [SCMC_PRE_W-1:0] cnt;
  logic [SCMC_PRE_W-1:0] next_cnt;

  always_comb
  begin
    next_cnt = cnt;
    if (src_tick)
    begin
      next_cnt = cnt + 1'b1; // [R2]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign periph_tick[0] = src_tick; // [R2]

  genvar k;
  generate
    for (k = 1; k < SCMC_TAPS; k = k + 1)
    begin : g_tap
      // Tap k fires once every 2**k source edges [R2]
      assign periph_tick[k] = src_tick & (&cnt[k-1:0]);
    end
  endgenerate

  property p_tap_on_edge;
    @(posedge hclk) disable iff (!hresetn)
    (periph_tick != '0) |-> src_tick;
  endproperty
  a_tap_on_edge: assert property (p_tap_on_edge) else $error("tap without source edge"); // [R2]

endmodule // scmc_prescaler

// *** src/scmc_top.sv ***
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// [R1] CPU clock divides source by 2/8/16/64
// [R2] Peripheral taps: undivided up to /1024
// [R3] Peripheral clock off during stop mode
// [R4] Source bit picks main or sub
// [R5] Oscillator bit stops main while on sub
// [R6] Reset starts at fastest divider
// [R7] Reset clears clock mode register
// [R8] Main active runs from main only
// [R9] Source change never pauses execution
// [R10] Software enters sub via 02h then 03h
// [R11] Software restarts main, waits, writes zero
// [R12] Reset in sub active gives main
// [R13] Sleep bit stops CPU clock only
// [R14] Sleep leaves on reset or interrupt
// [R15] Stop halts main, sub keeps running
// [R16] Stop leaves on listed wake events
// [R17] Reset from stop gives main active
// [R18] Stop holds all internal state
// [R19] Clock switching is glitch-free
module scmc_top
  import scmc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic stop_exec,
  input wire logic irq_pending,
  input wire logic key_scan_irq,
  input wire logic watch_timer_irq,
  input wire logic timer_event_input,
  input wire logic serial_port_unit_event,
  input wire logic ext_irq,
  output logic cpu_clk_en,
  output logic [scmc_pkg::SCMC_TAPS-1:0] periph_tick,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic [1:0] op_mode
);
  import scmc_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic dp_write;
  logic next_dp_write;
  logic [7:0] dp_addr;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic ap_take;

  logic [7:0] clock_mode_reg;
  logic [7:0] next_clock_mode;
  scmc_state_t state;
  scmc_state_t next_state;
  logic src_tick;
  logic cpu_tick;
  logic src_is_sub;
  logic stop_wake;
  logic sleep_wr;
  logic [1:0] next_op_mode;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_take = hsel & hready & htrans[1];

  // Mode, sleep and status mode fields return next-cycle values so a write just ahead is seen
  always_comb
  begin
    next_dp_write = ap_take & hwrite;
    next_dp_addr = ap_take ? haddr[7:0] : dp_addr;
    next_hrdata = hrdata;
    if (ap_take && !hwrite)
    begin
      case (haddr[7:0])
        SCMC_CLOCK_MODE_OFF: next_hrdata = {24'h000000, next_clock_mode};
        SCMC_SLEEP_CTRL_OFF: next_hrdata = {31'h00000000, next_state == SCMC_SLEEP};
        SCMC_STATUS_OFF:
        begin
          next_hrdata = 32'h00000000;
          next_hrdata[SCMC_ST_MODE_MSB:SCMC_ST_MODE_LSB] = next_op_mode;
          next_hrdata[SCMC_ST_MAIN_ON_BIT] = main_osc_en;
          next_hrdata[SCMC_ST_SRC_SUB_BIT] = src_is_sub;
        end
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Clock mode register
  // ----------------------------------------------------------------
  always_comb
  begin
    next_clock_mode = clock_mode_reg;
    // Writes are dropped in stop so nothing moves while frozen
    if (dp_write && dp_addr == SCMC_CLOCK_MODE_OFF && state != SCMC_STOP) // [R18]
    begin
      next_clock_mode = hwdata[7:0] & SCMC_CM_WR_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clock_mode_reg <= SCMC_CM_RESET; // [R7] [R12] [R17]
    else
      clock_mode_reg <= next_clock_mode;
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  assign sleep_wr = dp_write && dp_addr == SCMC_SLEEP_CTRL_OFF && hwdata[SCMC_SLEEP_EN_BIT];
  assign stop_wake = key_scan_irq | watch_timer_irq | timer_event_input |
                     serial_port_unit_event | ext_irq;

  always_comb
  begin
    next_state = state;
    case (state)
      SCMC_RUN:
      begin
        if (stop_exec)
          next_state = SCMC_STOP; // [R15]
        else if (sleep_wr && !irq_pending)
          next_state = SCMC_SLEEP; // [R13]
      end
      SCMC_SLEEP:
      begin
        if (irq_pending)
          next_state = SCMC_RUN; // [R14]
      end
      SCMC_STOP:
      begin
        if (stop_wake)
          next_state = SCMC_RUN; // [R16]
      end
      default: next_state = SCMC_RUN;
    endcase
  end

  always_comb
  begin
    if (next_state == SCMC_STOP)
      next_op_mode = SCMC_MODE_STOP;
    else if (next_state == SCMC_SLEEP)
      next_op_mode = SCMC_MODE_SLEEP;
    else if (src_is_sub)
      next_op_mode = SCMC_MODE_SUB_ACT;
    else
      next_op_mode = SCMC_MODE_MAIN_ACT;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= SCMC_RUN; // [R12] [R17]
      op_mode <= SCMC_MODE_MAIN_ACT;
    end
    else
    begin
      state <= next_state;
      op_mode <= next_op_mode;
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  // Main is held on until the selector has really left it, else
  // the selector would wait forever for a main edge
  assign main_osc_en = (state != SCMC_STOP) &&
    (!(clock_mode_reg[SCMC_CM_SRC_SUB_BIT] && clock_mode_reg[SCMC_CM_OSC_STOP_BIT])
     || !src_is_sub); // [R5] [R15]
  assign sub_osc_en = 1'b1; // [R15]
  // CPU keeps ticking across a source change [R9]
  assign cpu_clk_en = cpu_tick && state == SCMC_RUN; // [R13]

  scmc_clk_select u_clk_select (
    .hclk(hclk),
    .hresetn(hresetn),
    .main_tick(main_osc_tick),
    .sub_tick(sub_osc_tick),
    .run_en(state != SCMC_STOP), // [R3] [R18]
    .want_sub(clock_mode_reg[SCMC_CM_SRC_SUB_BIT]), // [R4] [R8]
    .div_sel(clock_mode_reg[SCMC_CM_DIV_MSB:SCMC_CM_DIV_LSB]), // [R1]
    .src_tick(src_tick),
    .cpu_tick(cpu_tick),
    .src_is_sub(src_is_sub)
  );

  scmc_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_tick(src_tick),
    .periph_tick(periph_tick)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_clear;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (clock_mode_reg == SCMC_CM_RESET && state == SCMC_RUN);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // [R7]

  property p_main_stop_bit;
    @(posedge hclk) disable iff (!hresetn)
    (state != SCMC_STOP && src_is_sub) |->
      main_osc_en == !(clock_mode_reg[SCMC_CM_SRC_SUB_BIT] && clock_mode_reg[SCMC_CM_OSC_STOP_BIT]);
  endproperty
  a_main_stop_bit: assert property (p_main_stop_bit) else $error("main osc enable wrong"); // [R5]

  property p_stop_osc;
    @(posedge hclk) disable iff (!hresetn)
    state == SCMC_STOP |-> (!main_osc_en && sub_osc_en && !cpu_clk_en);
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillators wrong in stop"); // [R15]

  property p_stop_periph;
    @(posedge hclk) disable iff (!hresetn)
    state == SCMC_STOP |-> periph_tick == '0;
  endproperty
  a_stop_periph: assert property (p_stop_periph) else $error("peripheral clock in stop"); // [R3]

  property p_sleep_cpu;
    @(posedge hclk) disable iff (!hresetn)
    state == SCMC_SLEEP |-> (!cpu_clk_en && main_osc_en == !(clock_mode_reg[SCMC_CM_SRC_SUB_BIT]
      && clock_mode_reg[SCMC_CM_OSC_STOP_BIT] && src_is_sub));
  endproperty
  a_sleep_cpu: assert property (p_sleep_cpu) else $error("cpu clock in sleep"); // [R13]

  property p_sleep_release;
    @(posedge hclk) disable iff (!hresetn)
    (state == SCMC_SLEEP && irq_pending) |=> state == SCMC_RUN ##1 op_mode != SCMC_MODE_SLEEP;
  endproperty
  a_sleep_release: assert property (p_sleep_release) else $error("sleep not released"); // [R14]

  property p_stop_release;
    @(posedge hclk) disable iff (!hresetn)
    (state == SCMC_STOP && stop_wake) |=> state == SCMC_RUN;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop not released"); // [R16]

  property p_stop_hold;
    @(posedge hclk) disable iff (!hresetn)
    state == SCMC_STOP |=> ($stable(clock_mode_reg) && $stable(src_is_sub));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop"); // [R18]

  property p_stop_entry;
    @(posedge hclk) disable iff (!hresetn)
    (state == SCMC_RUN && stop_exec) |=> (state == SCMC_STOP && op_mode == SCMC_MODE_STOP);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered"); // [R15]

  property p_sleep_entry;
    @(posedge hclk) disable iff (!hresetn)
    (state == SCMC_RUN && !stop_exec && sleep_wr && !irq_pending) |=> state == SCMC_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered"); // [R13]

  // Outside stop, a main source must never lose its oscillator, or the CPU would hang
  property p_main_active_osc;
    @(posedge hclk) disable iff (!hresetn)
    (state != SCMC_STOP && !src_is_sub) |-> main_osc_en;
  endproperty
  a_main_active_osc: assert property (p_main_active_osc) else $error("main osc off"); // [R8]

  property p_sleep_source;
    @(posedge hclk) disable iff (!hresetn)
    state == SCMC_SLEEP |-> src_tick == (src_is_sub ? sub_osc_tick : main_osc_tick);
  endproperty
  a_sleep_source: assert property (p_sleep_source) else $error("source gated in sleep"); // [R13]

  property p_cpu_tick_run;
    @(posedge hclk) disable iff (!hresetn)
    (state == SCMC_RUN && cpu_tick) |-> cpu_clk_en;
  endproperty
  a_cpu_tick_run: assert property (p_cpu_tick_run) else $error("cpu tick dropped"); // [R9]

endmodule // scmc_top
